// File: hdl/rpm_sequencer.sv
/*
 * radio power-mode sequencer with axi4-lite register slave and interrupt.
 * assumes an axi4-lite master on aclk, supply comparator inputs synchronous
 * to aclk, and a fifo whose empty flag is presented on fifo_empty.
 */
// Added by the designer: register access over AXI4-Lite and the register addresses.
module rpm_sequencer #(
    parameter int XTAL_CYC = rpm_pkg::XTAL_SETTLE_CYC,
    parameter int REG_CYC = rpm_pkg::REG_SETTLE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic supply_low,
    input wire logic fifo_empty,
    output logic core_supply_en,
    output logic all_supply_en,
    output logic xtal_en,
    output logic synth_en,
    output logic rx_en,
    output logic tx_en,
    output logic fifo_access_en,
    output logic fifo_flush,
    output logic reg_file_clear,
    output logic irq
);
    import rpm_pkg::*;

    logic [7:0] aw_addr; // latched write address
    logic aw_have; // write address held
    logic [31:0] w_data; // latched write data
    logic [3:0] w_strb; // latched strobes
    logic w_have; // write data held
    logic [3:0] radio_power_mode_reg; // requested mode
    logic [3:0] cur_mode; // mode in effect
    logic [31:0] scratch; // retained user word
    logic [STAT_W-1:0] irq_stat; // sticky events
    logic [STAT_W-1:0] irq_mask; // enables
    logic [STAT_W-1:0] events; // one-cycle event pulses
    rpm_reg_t reg_state; // regulator state
    logic regulator_ready_flag; // regulated supplies ready
    logic brownout_flag; // supply below threshold
    logic xtal_ok; // crystal settled
    logic reg_done; // regulator ramp over
    logic xtal_done; // crystal timer over
    logic mode_write; // mode register written
    logic wr_fire; // write executes
    logic need_xtal; // mode needs oscillator
    logic pend_empty; // waiting for empty fifo
    logic prev_ready; // edge detect
    logic prev_bo; // edge detect
    logic prev_xtal; // edge detect

    assign wr_fire = aw_have && w_have && !s_axi_bvalid;
    assign mode_write = wr_fire && aw_addr == OFS_MODE && w_strb[0];
    assign need_xtal = cur_mode != MODE_CORE_OFF && cur_mode != MODE_TOTAL_OFF && cur_mode != MODE_WOR;

    // write address and data taken independently, one of each held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have <= 1'b0;
            end
        end
    end

    // ready while nothing held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready <= !w_have && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // write response, error on unmapped or read-only offset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            case (aw_addr)
                OFS_MODE, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_SCRATCH: s_axi_bresp <= RESP_OKAY;
                default: s_axi_bresp <= RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // mode register, scratch and mask; total-off wipes retained contents
    always_ff @(posedge aclk) begin
        if (!aresetn || cur_mode == MODE_TOTAL_OFF) begin
            radio_power_mode_reg <= RST_MODE;
            scratch <= RST_SCRATCH;
            irq_mask <= '0;
        end else if (wr_fire) begin
            if (mode_write) begin
                radio_power_mode_reg <= w_data[3:0];
            end
            if (aw_addr == OFS_SCRATCH) begin
                for (int i = 0; i < 4; i++) begin
                    if (w_strb[i]) begin
                        scratch[8*i +: 8] <= w_data[8*i +: 8];
                    end
                end
            end
            if (aw_addr == OFS_IRQ_MASK && w_strb[0]) begin
                irq_mask <= w_data[STAT_W-1:0];
            end
        end
    end

    // mode takes effect; core-off and oscillator-only wait for empty fifo
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cur_mode <= RST_MODE;
            pend_empty <= 1'b0;
        end else if (radio_power_mode_reg != cur_mode) begin
            if ((radio_power_mode_reg == MODE_CORE_OFF || radio_power_mode_reg == MODE_OSC_ONLY)
                && !fifo_empty) begin
                pend_empty <= 1'b1;
            end else begin
                cur_mode <= radio_power_mode_reg;
                pend_empty <= 1'b0;
            end
        end else begin
            pend_empty <= 1'b0;
        end
    end

    // regulator state follows the mode with no separate command
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reg_state <= REG_OFF;
        end else begin
            case (reg_state)
                REG_OFF: if (need_xtal) reg_state <= REG_RAMP;
                REG_RAMP: if (!need_xtal) reg_state <= REG_OFF;
                    else if (reg_done) reg_state <= REG_ON;
                REG_ON: if (!need_xtal) reg_state <= REG_OFF;
                default: reg_state <= REG_OFF;
            endcase
        end
    end

    rpm_settle_timer #(.COUNT(REG_CYC)) u_reg_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(1'b0),
        .run(reg_state == REG_RAMP),
        .done(reg_done)
    );

    rpm_settle_timer #(.COUNT(XTAL_CYC)) u_xtal_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .restart(1'b0),
        .run(need_xtal),
        .done(xtal_done)
    );

    // status flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            regulator_ready_flag <= 1'b0;
            brownout_flag <= 1'b0;
            xtal_ok <= 1'b0;
        end else begin
            regulator_ready_flag <= reg_state == REG_ON && !supply_low;
            brownout_flag <= supply_low;
            xtal_ok <= need_xtal && (xtal_ok || xtal_done);
        end
    end

    // supply and function enables per mode
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_supply_en <= 1'b0;
            all_supply_en <= 1'b1;
            xtal_en <= 1'b0;
            synth_en <= 1'b0;
            rx_en <= 1'b0;
            tx_en <= 1'b0;
            fifo_access_en <= 1'b0;
            fifo_flush <= 1'b0;
            reg_file_clear <= 1'b0;
        end else begin
            core_supply_en <= reg_state == REG_ON;
            all_supply_en <= cur_mode != MODE_TOTAL_OFF;
            reg_file_clear <= cur_mode == MODE_TOTAL_OFF;
            xtal_en <= need_xtal;
            synth_en <= reg_state == REG_ON && (cur_mode == MODE_SYNTH_RX || cur_mode == MODE_RX_ACTIVE
                || cur_mode == MODE_SYNTH_TX || cur_mode == MODE_TX_ACTIVE);
            rx_en <= reg_state == REG_ON && cur_mode == MODE_RX_ACTIVE;
            tx_en <= reg_state == REG_ON && cur_mode == MODE_TX_ACTIVE;
            fifo_access_en <= cur_mode != MODE_CORE_OFF && cur_mode != MODE_TOTAL_OFF
                && cur_mode != MODE_OSC_ONLY && cur_mode != MODE_WOR;
            fifo_flush <= cur_mode == MODE_CORE_OFF || cur_mode == MODE_TOTAL_OFF
                || cur_mode == MODE_OSC_ONLY;
        end
    end

    // rising edges of the flags become events
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_ready <= 1'b0;
            prev_bo <= 1'b0;
            prev_xtal <= 1'b0;
        end else begin
            prev_ready <= regulator_ready_flag;
            prev_bo <= brownout_flag;
            prev_xtal <= xtal_ok;
        end
    end

    always_comb begin
        events = '0;
        events[BIT_REG_READY] = regulator_ready_flag && !prev_ready;
        events[BIT_BROWNOUT] = brownout_flag && !prev_bo;
        events[BIT_XTAL_OK] = xtal_ok && !prev_xtal;
        events[BIT_MODE_DONE] = mode_write;
    end

    // sticky status, write one to clear, a new event wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= '0;
        end else if (wr_fire && aw_addr == OFS_IRQ_STAT && w_strb[0]) begin
            irq_stat <= (irq_stat & ~w_data[STAT_W-1:0]) | events;
        end else begin
            irq_stat <= irq_stat | events;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    // read channel, one read at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= RESP_OKAY;
                s_axi_rdata <= 32'h0000_0000;
                case (s_axi_araddr)
                    OFS_MODE: s_axi_rdata[3:0] <= radio_power_mode_reg;
                    OFS_STAT: begin
                        s_axi_rdata[BIT_REG_READY] <= regulator_ready_flag;
                        s_axi_rdata[BIT_BROWNOUT] <= brownout_flag;
                        s_axi_rdata[BIT_XTAL_OK] <= xtal_ok;
                        s_axi_rdata[BIT_MODE_DONE] <= !pend_empty && radio_power_mode_reg == cur_mode;
                        s_axi_rdata[11:8] <= cur_mode;
                    end
                    OFS_IRQ_STAT: s_axi_rdata[STAT_W-1:0] <= irq_stat;
                    OFS_IRQ_MASK: s_axi_rdata[STAT_W-1:0] <= irq_mask;
                    OFS_SCRATCH: s_axi_rdata <= scratch;
                    default: s_axi_rresp <= RESP_SLVERR;
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

// File: hdl/rpm_pkg.sv
/*
 * constants for the radio power-mode sequencer: register offsets, mode codes,
 * field positions, reset values and settling time.
 * assumes a 20 mhz aclk and an axi4-lite master with 32-bit data.
 */
package rpm_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_SCRATCH = 8'h10;
    // power mode codes
    localparam logic [3:0] MODE_CORE_OFF = 4'h0;
    localparam logic [3:0] MODE_TOTAL_OFF = 4'h1;
    localparam logic [3:0] MODE_OSC_ONLY = 4'h5;
    localparam logic [3:0] MODE_FIFO = 4'h6;
    localparam logic [3:0] MODE_SYNTH_RX = 4'h8;
    localparam logic [3:0] MODE_RX_ACTIVE = 4'h9;
    localparam logic [3:0] MODE_WOR = 4'hB;
    localparam logic [3:0] MODE_SYNTH_TX = 4'hC;
    localparam logic [3:0] MODE_TX_ACTIVE = 4'hD;
    // status bit positions (status and interrupt registers)
    localparam int BIT_REG_READY = 0;
    localparam int BIT_BROWNOUT = 1;
    localparam int BIT_XTAL_OK = 2;
    localparam int BIT_MODE_DONE = 3;
    localparam int STAT_W = 4;
    // reset values
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [31:0] RST_SCRATCH = 32'h0000_0000;
    // settling figures
    localparam int CLK_HZ = 20_000_000;
    localparam int XTAL_SETTLE_US = 3000;
    localparam int XTAL_SETTLE_CYC = (CLK_HZ / 1_000_000) * XTAL_SETTLE_US;
    localparam int REG_SETTLE_CYC = 16;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // regulator states
    typedef enum logic [1:0] {
        REG_OFF = 2'b00,
        REG_RAMP = 2'b01,
        REG_ON = 2'b10
    } rpm_reg_t;
endpackage

// File: hdl/rpm_settle_timer.sv
/*
 * settle timer: counts a fixed number of cycles after a restart while run is high.
 * assumes run and restart are synchronous to aclk.
 */
module rpm_settle_timer #(
    parameter int COUNT = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic restart,
    input wire logic run,
    output logic done
);
    localparam int W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LAST = W'(COUNT);
    logic [W-1:0] cnt; // elapsed cycles

    // counter restarts on request, holds at its end, clears when idle
    always_ff @(posedge aclk) begin
        if (!aresetn || restart || !run) begin
            cnt <= '0;
            done <= 1'b0;
        end else if (cnt != LAST) begin
            cnt <= cnt + W'(1);
            done <= (cnt == LAST - W'(1));
        end
    end
endmodule

// File: verification/rpm_seq_sva.sv
/* checker: answer timing and output exclusions of the power sequencer.
   assumes a bind into rpm_sequencer, one clock and a sync active-low reset. */
module rpm_seq_sva #(
    parameter int XTAL_CYC = rpm_pkg::XTAL_SETTLE_CYC,
    parameter int REG_CYC = rpm_pkg::REG_SETTLE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic fifo_empty,
    input wire logic core_supply_en,
    input wire logic all_supply_en,
    input wire logic xtal_en,
    input wire logic synth_en,
    input wire logic rx_en,
    input wire logic tx_en,
    input wire logic fifo_access_en,
    input wire logic fifo_flush,
    input wire logic reg_file_clear
);
    timeunit 1ns;
    timeprecision 100ps;
    import rpm_pkg::*;
    // one domain, reset silences every property
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // both write halves taken on one edge
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    a_write_answer: assert property (wr_taken |-> ##[1:3] s_axi_bvalid) else $error("no write answer");
    a_rx_chain: assert property (rx_en |-> synth_en && xtal_en && core_supply_en) else $error("rx alone");
    a_tx_excl: assert property (tx_en |-> synth_en && !rx_en) else $error("tx with rx");
    a_synth_core: assert property (synth_en |-> core_supply_en && xtal_en) else $error("synth unpowered");
    a_flush_block: assert property (fifo_flush |-> !fifo_access_en) else $error("fifo open");
    a_total_off: assert property (reg_file_clear |-> !all_supply_en && !xtal_en) else $error("clear out of off");
    a_supply_cut: assert property (!all_supply_en |-> !(synth_en || rx_en || tx_en)) else $error("radio on");
    a_flush_empty: assert property ($rose(fifo_flush) |-> $past(fifo_empty) || $past(fifo_empty, 2))
        else $error("flush with data");
endmodule
bind rpm_sequencer rpm_seq_sva #(.XTAL_CYC(XTAL_CYC), .REG_CYC(REG_CYC)) u_sva (.*);

// File: verification/rpm_host_model.sv
/* host model: axi4-lite master that programs the sequencer registers.
   assumes the bench calls its tasks and shares aclk with the sequencer. */
module rpm_host_model (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 100ps;
    // idle bus from time zero
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    // one write, each half released at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad;
        logic dd;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        ad = 1'b0;
        dd = 1'b0;
        while (!(ad && dd)) begin
            @(posedge aclk);
            ad = ad | s_axi_awready;
            dd = dd | s_axi_wready;
            if (ad) s_axi_awvalid <= 1'b0;
            if (dd) s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid) @(posedge aclk);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    // one read, rready held until data arrives
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule

// File: verification/testbench.sv
/* testbench: walks the sequencer through its power modes via the host model.
   assumes the checker is bound and the host model is compiled before it. */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import rpm_pkg::*;
    localparam int XC = 40, RC = 16, WAITC = XC + RC + 8; // short crystal settling
    logic aclk = 1'b0;
    logic aresetn, supply_low, fifo_empty;
    logic [7:0] s_axi_awaddr, s_axi_araddr, outv;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic core_supply_en, all_supply_en, xtal_en, synth_en, rx_en, tx_en;
    logic fifo_access_en, fifo_flush, reg_file_clear, irq;
    int err_total = 0, checked = 0;
    // mode, then {core, xtal, synth, rx, tx, fifo access, flush, all supply}
    logic [11:0] rows [10] = '{12'h003, 12'h5C3, 12'h9F5, 12'h003, 12'h6C5, 12'h8E5, 12'hCE5, 12'hDED, 12'hB01, 12'h9F5};
    assign outv = {core_supply_en, xtal_en, synth_en, rx_en, tx_en, fifo_access_en, fifo_flush, all_supply_en};
    always #25 aclk = ~aclk;
    rpm_sequencer #(.XTAL_CYC(XC), .REG_CYC(RC)) uut (.*);
    rpm_host_model host (.*);
    // compare and count
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // verdict and end of run
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (5000) @(posedge aclk);
        err_total++;
        complete_run();
    end
    initial begin
        aresetn <= 1'b0;
        {supply_low, fifo_empty} <= 2'b01;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        // mode table, opening with off, oscillator, receive, off
        foreach (rows[i]) begin
            host.wr(OFS_MODE, 32'(rows[i][11:8]), r);
            repeat (WAITC) @(posedge aclk);
            chk("outputs", outv, rows[i][7:0]);
            host.rd(OFS_STAT, d, r);
            chk("mode in effect", d[11:8], rows[i][11:8]);
            chk("ready bit", d[BIT_REG_READY], rows[i][7]);
            chk("crystal bit", d[BIT_XTAL_OK], rows[i][6]);
        end
        $display("mode table done");
        // core-off waits for the fifo to drain
        fifo_empty <= 1'b0;
        host.wr(OFS_MODE, 32'h0000_0000, r);
        repeat (20) @(posedge aclk);
        chk("flush early", fifo_flush, 1'b0);
        chk("rx kept", rx_en, 1'b1);
        fifo_empty <= 1'b1;
        repeat (WAITC) @(posedge aclk);
        chk("flush", fifo_flush, 1'b1);
        chk("fifo blocked", fifo_access_en, 1'b0);
        $display("fifo gate done");
        // brown-out raises the masked-in interrupt, cleared by writing one
        host.wr(OFS_IRQ_STAT, 32'h0000_000F, r);
        host.wr(OFS_IRQ_MASK, 32'h0000_0002, r);
        supply_low <= 1'b1;
        repeat (4) @(posedge aclk);
        chk("irq raised", irq, 1'b1);
        host.rd(OFS_STAT, d, r);
        chk("brownout bit", d[BIT_BROWNOUT], 1'b1);
        host.wr(OFS_IRQ_STAT, 32'h0000_0002, r);
        repeat (4) @(posedge aclk);
        chk("irq cleared", irq, 1'b0);
        $display("brownout done");
        // total-off loses registers; bus refusals
        host.wr(OFS_SCRATCH, 32'hA5A5_0F0F, r);
        host.rd(OFS_SCRATCH, d, r);
        chk("scratch", d, 32'hA5A5_0F0F);
        host.wr(OFS_MODE, 32'h0000_0001, r);
        repeat (2) @(posedge aclk);
        chk("register clear", reg_file_clear, 1'b1);
        repeat (18) @(posedge aclk);
        host.rd(OFS_SCRATCH, d, r);
        chk("scratch lost", d, 32'h0000_0000);
        host.rd(OFS_MODE, d, r);
        chk("mode lost", d, 32'h0000_0000);
        host.wr(OFS_STAT, 32'h0000_0001, r);
        chk("status write", r, RESP_SLVERR);
        host.rd(8'h14, d, r);
        chk("unmapped", r, RESP_SLVERR);
        $display("total off done");
        // reset in mid-run from oscillator-only
        host.wr(OFS_MODE, 32'h0000_0005, r);
        repeat (WAITC) @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("reset outputs", outv, 8'h01);
        aresetn <= 1'b1;
        host.rd(OFS_MODE, d, r);
        chk("reset mode", d, 32'h0000_0000);
        $display("reset done");
        complete_run();
    end
endmodule
